// ===== shared/io_cfg_pkg.sv
/*
  constants for the second core's input/output path configuration block:
  register offsets, field positions, reset values and mode encodings.
  assumes a 32-bit apb slave with word-aligned byte addresses.
*/
package io_cfg_pkg;
  localparam logic [11:0] CFG_OFFSET    = 12'h00c;
  localparam logic [11:0] IRQ_STAT_OFF  = 12'h020;
  localparam logic [11:0] IRQ_MASK_OFF  = 12'h024;
  localparam logic [11:0] IN_DATA_OFF   = 12'h028;

  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
  localparam logic [31:0] CFG_WR_MASK   = 32'hfdff_dfff;

  localparam int IN_MODE_LSB   = 0;
  localparam int EDGE_BIT      = 2;
  localparam int IN_DIV0_LSB   = 3;
  localparam int IN_DIV1_LSB   = 8;
  localparam int START_BIT     = 13;
  localparam int OUT_MODE_BIT  = 14;
  localparam int OUT_DIV0_LSB  = 15;
  localparam int OUT_DIV1_LSB  = 20;
  localparam int SHADOW_BIT    = 25;
  localparam int DIV_W         = 5;
  localparam int STROBE_BIT    = 16;
  localparam int STATUS_SB_BIT = 29;
  localparam int SHIFT_W       = 28;
  localparam int CAP_W         = 16;

  localparam logic [4:0] DIV_RESERVED = 5'h1f;
  localparam logic [2:0] IRQ_RESET    = 3'h0;

  typedef enum logic [1:0] {
    IN_DIRECT   = 2'b00,
    IN_PARALLEL = 2'b01,
    IN_SHIFT    = 2'b10,
    IN_MII_RT   = 2'b11
  } in_mode_t;
endpackage

// ===== src/half_step_div.sv
/*
  half-step fractional divider: code n divides the en_in tick rate by (n+2)/2, emitting a
  one-cycle enable pulse. assumes pclk domain and a source enable input.
*/
`timescale 1ns/1ns
module half_step_div
  import io_cfg_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             en_in,
  input  wire logic [DIV_W-1:0] code,
  output logic                  en_out
);
  // accumulate 2 per input tick, fire when reaching code+2 (ratio (code+2)/2)
  logic [6:0] acc_q, acc_d;
  logic [6:0] lim;
  logic       fire;

  always_comb begin
    lim    = 7'(code) + 7'd2;
    fire   = en_in && ((acc_q + 7'd2) >= lim);
    acc_d  = acc_q;
    if (en_in) begin
      acc_d = fire ? 7'((acc_q + 7'd2) - lim) : 7'(acc_q + 7'd2);
    end
    // reserved code: ratio undefined, kept harmless
    if (code == DIV_RESERVED) begin
      acc_d = 7'd0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q  <= 7'd0;
      en_out <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      en_out <= fire && (code != DIV_RESERVED);
    end
  end
endmodule

// ===== src/io_path_cfg.sv
/*
  configuration register and input/output path control for the second
  core's enhanced io. apb slave on pclk; input pins arrive asynchronously
  and are synchronised here. output pins driven from flip-flops.
*/
`timescale 1ns/1ns
module io_path_cfg
  import io_cfg_pkg::*;
#(
  parameter int IN_W = 32
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [IN_W-1:0]  in_pins,
  input  wire logic [31:0]      core_output_register,
  output logic      [31:0]      core_input_register,
  output logic      [31:0]      out_pins,
  output logic                  irq
);
  logic [31:0]     cfg_q, cfg_d;
  logic [IN_W-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
  logic [SHIFT_W-1:0] shift_q, shift_d;
  logic [CAP_W-1:0]   cap_q, cap_d;
  logic [31:0]     osh_a_q, osh_a_d, osh_b_q, osh_b_d;
  logic [4:0]      ocnt_q, ocnt_d;
  logic [31:0]     out_q, out_d;
  logic [2:0]      ist_q, ist_d, imask_q, imask_d;
  logic [31:0]     rdata_d;
  logic            wr, rd, strobe_prev_q;
  logic            in_en_a, in_en, out_en_a, out_en;
  logic            sb_set, cap_evt, shadow_evt, strobe_edge;
  in_mode_t        in_mode;

  function automatic logic [DIV_W-1:0] fld(input logic [31:0] r, input int lsb);
    fld = r[lsb +: DIV_W];
  endfunction

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign in_mode = in_mode_t'(cfg_q[IN_MODE_LSB +: 2]);

  // three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= in_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end
  always_comb begin
    for (int i = 0; i < IN_W; i++) begin
      pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
    end
  end

  // cascaded dividers per path
  half_step_div u_in_div0 (.pclk(pclk), .presetn(presetn), .en_in(1'b1),
    .code(fld(cfg_q, IN_DIV0_LSB)), .en_out(in_en_a));
  half_step_div u_in_div1 (.pclk(pclk), .presetn(presetn), .en_in(in_en_a),
    .code(fld(cfg_q, IN_DIV1_LSB)), .en_out(in_en));
  half_step_div u_out_div0 (.pclk(pclk), .presetn(presetn), .en_in(1'b1),
    .code(fld(cfg_q, OUT_DIV0_LSB)), .en_out(out_en_a));
  half_step_div u_out_div1 (.pclk(pclk), .presetn(presetn), .en_in(out_en_a),
    .code(fld(cfg_q, OUT_DIV1_LSB)), .en_out(out_en));

  // strobe edge on synced bit 16
  assign strobe_edge = cfg_q[EDGE_BIT] ? (strobe_prev_q && !pin_q[STROBE_BIT])
                                       : (!strobe_prev_q && pin_q[STROBE_BIT]);

  // input capture
  always_comb begin
    shift_d = shift_q;
    cap_d   = cap_q;
    sb_set  = 1'b0;
    cap_evt = 1'b0;
    case (in_mode)
      IN_PARALLEL: begin
        if (strobe_edge) begin
          cap_d   = pin_q[CAP_W-1:0];
          cap_evt = 1'b1;
        end
      end
      IN_SHIFT: begin
        if (in_en) begin
          shift_d = {shift_q[SHIFT_W-2:0], pin_q[0]};
          // first captured one raises the start flag
          sb_set  = pin_q[0] && !cfg_q[START_BIT];
        end
      end
      default: begin
      end
    endcase
    // clearing the flag wipes the shift register; a one arriving in that cycle shifts in only if the flag was already clear
    if (wr && paddr == CFG_OFFSET && pwdata[START_BIT]) begin
      shift_d = sb_set ? {{(SHIFT_W-1){1'b0}}, 1'b1} : '0;
    end
  end

  // config register: set wins over write-one clear
  always_comb begin
    cfg_d = cfg_q;
    if (wr && paddr == CFG_OFFSET) begin
      cfg_d = (cfg_q & ~CFG_WR_MASK) | (pwdata & CFG_WR_MASK);
      cfg_d[31:26] = 6'h00;
      cfg_d[START_BIT] = cfg_q[START_BIT] & ~pwdata[START_BIT];
    end
    if (sb_set) begin
      cfg_d[START_BIT] = 1'b1;
    end
    cfg_d[SHADOW_BIT] = shadow_evt ? ~cfg_q[SHADOW_BIT] : cfg_q[SHADOW_BIT];
  end

  // output path: serial shifts from active shadow, reload other, then swap
  always_comb begin
    osh_a_d    = osh_a_q;
    osh_b_d    = osh_b_q;
    ocnt_d     = ocnt_q;
    out_d      = out_q;
    shadow_evt = 1'b0;
    if (!cfg_q[OUT_MODE_BIT]) begin
      out_d  = core_output_register;
      ocnt_d = 5'd0;
    end else if (!out_en) begin
      // between ticks hold only the serial bit, never a stale direct word
      out_d = {31'd0, out_q[0]};
    end else begin
      if (!cfg_q[SHADOW_BIT]) begin
        out_d   = {31'd0, osh_a_q[0]};
        osh_a_d = {1'b0, osh_a_q[31:1]};
        osh_b_d = core_output_register;
      end else begin
        out_d   = {31'd0, osh_b_q[0]};
        osh_b_d = {1'b0, osh_b_q[31:1]};
        osh_a_d = core_output_register;
      end
      ocnt_d = 5'(ocnt_q + 5'd1);
      shadow_evt = (ocnt_q == 5'd31);
    end
  end

  // interrupt status: 0 start bit, 1 parallel capture, 2 shadow swap
  always_comb begin
    ist_d   = ist_q;
    imask_d = imask_q;
    if (wr && paddr == IRQ_STAT_OFF) begin
      ist_d = ist_q & ~pwdata[2:0];
    end
    if (wr && paddr == IRQ_MASK_OFF) begin
      imask_d = pwdata[2:0];
    end
    ist_d = ist_d | {shadow_evt, cap_evt, sb_set};
  end

  always_comb begin
    case (paddr)
      CFG_OFFSET:   rdata_d = cfg_q;
      IRQ_STAT_OFF: rdata_d = {29'd0, ist_q};
      IRQ_MASK_OFF: rdata_d = {29'd0, imask_q};
      IN_DATA_OFF:  rdata_d = core_input_register;
      default:      rdata_d = 32'h0000_0000;
    endcase
  end

  // input register view per mode; in shift mode status bit 29 mirrors the start flag
  always_comb begin
    case (in_mode)
      IN_PARALLEL: core_input_register = {16'd0, cap_q};
      IN_SHIFT:    core_input_register = {2'b00, cfg_q[START_BIT], 1'b0, shift_q};
      default:     core_input_register = 32'(pin_q);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q         <= CFG_RESET;
      shift_q       <= '0;
      cap_q         <= '0;
      osh_a_q       <= '0;
      osh_b_q       <= '0;
      ocnt_q        <= 5'd0;
      out_q         <= '0;
      ist_q         <= IRQ_RESET;
      imask_q       <= IRQ_RESET;
      strobe_prev_q <= 1'b0;
      prdata        <= '0;
    end else begin
      cfg_q         <= cfg_d;
      shift_q       <= shift_d;
      cap_q         <= cap_d;
      osh_a_q       <= osh_a_d;
      osh_b_q       <= osh_b_d;
      ocnt_q        <= ocnt_d;
      out_q         <= out_d;
      ist_q         <= ist_d;
      imask_q       <= imask_d;
      strobe_prev_q <= pin_q[STROBE_BIT];
      if (rd) begin
        prdata <= rdata_d;
      end
    end
  end

  assign out_pins = out_q;
  assign irq      = |(ist_q & imask_q);
endmodule

// ===== sim/io_path_cfg_checker.sv
/* port assertions for io_path_cfg.
   assumes a bind onto its ports. */
`timescale 1ns/1ns
module io_path_cfg_checker
  import io_cfg_pkg::*;
(
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, irq,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata, core_output_register,
  input wire logic [31:0] core_input_register, out_pins
);
  logic [31:0] cfg_q;
  logic [2:0]  mask_q;
  wire         rd_cfg = psel & penable & !pwrite & paddr == CFG_OFFSET;
  wire         wr_acc = psel & penable & pwrite;
  // software view only: hardware-owned bits are never compared to it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) begin
      cfg_q  <= 32'h0;
      mask_q <= 3'h0;
    end else if (wr_acc && paddr == CFG_OFFSET)
      cfg_q <= pwdata;
    else if (wr_acc && paddr == IRQ_MASK_OFF)
      mask_q <= pwdata[2:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel |-> pready)
    else $error("wait state");
  a_cfg_read: assert property (rd_cfg |-> prdata[31:26] == 6'h0
    && {prdata[24:14], prdata[12:0]} == {cfg_q[24:14], cfg_q[12:0]}) else $error("cfg");
  a_flag_mirror: assert property (rd_cfg && cfg_q[1:0] == IN_SHIFT |->
    prdata[13] == $past(core_input_register[29])) else $error("flag mirror");
  a_shift_pad: assert property (cfg_q[1:0] == IN_SHIFT |->
    core_input_register[31:30] == 2'h0 && !core_input_register[28]) else $error("pad");
  a_capture_top: assert property (cfg_q[1:0] == IN_PARALLEL |->
    core_input_register[31:16] == 16'h0) else $error("capture");
  a_direct_out: assert property ($past(presetn) && !$past(cfg_q[14]) |->
    out_pins == $past(core_output_register)) else $error("direct out");
  a_serial_out: assert property ($past(presetn) && $past(cfg_q[14]) |->
    out_pins[31:1] == 31'h0) else $error("serial out");
  a_irq_masked: assert property ((mask_q == 3'h0) [*2] |-> !irq) else $error("irq");
endmodule

// ===== sim/pin_model.sv
/* far side: input pins and the core's output word.
   assumes nonblocking stimulus from the bench. */
`timescale 1ns/1ns
module pin_model (
  input  wire logic        pclk,
  input  wire logic [31:0] pin_d, word_d,
  output logic      [31:0] in_pins = 32'h0, core_output_register = 32'h0
);
  // extra stage stands for the board path ahead of the synchroniser
  always_ff @(posedge pclk) begin
    in_pins              <= pin_d;
    core_output_register <= word_d;
  end
endmodule

// ===== sim/testbench.sv
/* bench: apb master and pin_model around io_path_cfg.
   assumes zero-wait apb on one clock. */
`timescale 1ns/1ns
module testbench;
  import io_cfg_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, pin_d = 0, word_d = 0, rd, w, prdata, in_pins;
  logic [31:0] core_output_register, core_input_register, out_pins;
  logic        pready, irq;
  int          fails = 0, samples_checked = 0, seed = 73;
  always #20 pclk = ~pclk;
  pin_model u_pin_model (.pclk, .pin_d, .word_d, .in_pins, .core_output_register);
  io_path_cfg u_io_path_cfg (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr(), .in_pins, .core_output_register, .core_input_register,
    .out_pins, .irq);
  task chk(string n, logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(logic wr, logic [11:0] a, logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    {psel, penable} <= 2'h0;
    repeat (2) @(posedge pclk);
  endtask
  task pins(logic [31:0] p, int n);
    pin_d <= p;
    repeat (n) @(posedge pclk);
  endtask
  // reserved divider code has no defined ratio, so it is never sent
  function automatic logic [31:0] legal(logic [31:0] v);
    int l[4] = '{3, 8, 15, 20};
    foreach (l[i]) if (v[l[i]+:5] == 5'h1f) v[l[i]+:5] = 5'h1e;
    return v & 32'hffff_9fff;
  endfunction
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(0, CFG_OFFSET, 0);
    chk("cfg reset", rd, CFG_RESET);
    for (int i = 0; i < 12; i++) begin
      w = legal(i ? $random(seed) : 32'hffff_ffff);
      w[1:0] = i[1:0];
      apb(1, CFG_OFFSET, w);
      apb(0, CFG_OFFSET, 0);
      chk("cfg", rd, w & 32'h01ff_dfff);
    end
    apb(1, CFG_OFFSET, 0);
    word_d <= $random(seed);
    pins($random(seed), 8);
    chk("out", out_pins, word_d);
    chk("in", core_input_register, pin_d);
    w = $random(seed);
    apb(1, CFG_OFFSET, 1);
    pins(0, 8);
    pins(w | 32'h1_0000, 8);
    chk("rise", core_input_register, {16'h0, w[15:0]});
    apb(1, CFG_OFFSET, 5);
    pins(~w & 32'hfffe_ffff, 8);
    chk("fall", core_input_register, {16'h0, ~w[15:0]});
    pins(0, 8);
    // slow sampling keeps the captured ones inside the shift register
    apb(1, CFG_OFFSET, 32'h20f2);
    apb(1, IRQ_STAT_OFF, 7);
    apb(1, IRQ_MASK_OFF, 7);
    pins(1, 40);
    pins(0, 8);
    chk("flag", core_input_register[29], 1);
    chk("irq", irq, 1);
    apb(1, CFG_OFFSET, 32'hf2);
    apb(0, CFG_OFFSET, 0);
    chk("flag kept", rd[13], 1);
    apb(1, IRQ_MASK_OFF, 0);
    chk("irq mask", irq, 0);
    apb(1, IRQ_STAT_OFF, 7);
    apb(1, IRQ_MASK_OFF, 7);
    chk("irq clear", irq, 0);
    apb(1, CFG_OFFSET, 32'h20f2);
    chk("shift clear", core_input_register, 0);
    apb(1, CFG_OFFSET, 32'h4000);
    for (int n = 0; n < 99 && !rd[25]; n++) apb(0, CFG_OFFSET, 0);
    chk("shadow", rd[25], 1);
    wrap_up;
  end
endmodule
bind io_path_cfg io_path_cfg_checker u_io_path_cfg_checker (.pclk, .presetn, .psel,
  .penable, .pwrite, .pready, .irq, .paddr, .pwdata, .prdata, .core_output_register,
  .core_input_register, .out_pins);
